// file: rtl/motion_report_registers.sv
// Motion status, displacement registers and motion accumulators
`timescale 1ns/1ps
module motion_report_registers #(
  parameter int ACC_W = 16
) (
  input  wire logic                                 sys_clk,
  input  wire logic                                 rst,
  input  wire motion_report_pkg::reg_req_type       reg_req,
  output logic [7:0]                                reg_rdata,
  input  wire motion_report_pkg::motion_sample_type motion_sample,
  input  wire logic [motion_report_pkg::RES_UNIT_W-1:0] res_units,
  input  wire motion_report_pkg::laser_status_type  laser_status
);

  localparam int SW = ACC_W + 2;

  logic signed [ACC_W-1:0] acc_x_r;
  logic signed [ACC_W-1:0] acc_y_r;
  logic [7:0]              disp_x_r;
  logic [7:0]              disp_y_r;
  logic                    accum_overflow_r;
  logic [7:0]              reg_rdata_r;

  logic                    status_rd;
  logic                    x_rd;
  logic                    y_rd;
  logic                    clr_wr;
  logic signed [SW-1:0]    lim;
  logic [7:0]              cap_x;
  logic [7:0]              cap_y;
  logic signed [SW-1:0]    sum_x;
  logic signed [SW-1:0]    sum_y;
  logic                    ovf_x;
  logic                    ovf_y;
  logic                    full_x;
  logic                    full_y;
  logic                    motion_pending;
  logic                    laser_cfg_complement_ok;
  logic                    laser_fault;
  logic [7:0]              status_byte;

  function automatic logic [7:0] sat8(input logic signed [ACC_W-1:0] v);
    if (v > $signed(ACC_W'(127))) begin
      return motion_report_pkg::DISP_POS_FULL;
    end else if (v < -$signed(ACC_W'(128))) begin
      return motion_report_pkg::DISP_NEG_FULL;
    end else begin
      return v[7:0];
    end
  endfunction

  function automatic logic signed [ACC_W-1:0] clamp(
    input logic signed [SW-1:0] v,
    input logic signed [SW-1:0] l
  );
    if (v > l) begin
      return l[ACC_W-1:0];
    end else if (v < -l) begin
      return ACC_W'(-l);
    end else begin
      return v[ACC_W-1:0];
    end
  endfunction

  assign status_rd = reg_req.rd &&
                     reg_req.addr == motion_report_pkg::MOTION_STATUS_ADDR;
  assign x_rd      = reg_req.rd &&
                     reg_req.addr == motion_report_pkg::X_DISP_ADDR;
  assign y_rd      = reg_req.rd &&
                     reg_req.addr == motion_report_pkg::Y_DISP_ADDR;
  assign clr_wr    = reg_req.wr &&
                     reg_req.addr == motion_report_pkg::MOTION_CLEAR_ADDR;

  assign lim = SW'({res_units, {motion_report_pkg::FULL_SCALE_SHIFT{1'b0}}});

  assign cap_x = status_rd ? sat8(acc_x_r) : 8'h00;
  assign cap_y = status_rd ? sat8(acc_y_r) : 8'h00;

  // Capture and new motion in one cycle so no count slips between them
  assign sum_x = SW'(acc_x_r) - SW'($signed(cap_x)) +
                 (motion_sample.valid ? SW'($signed(motion_sample.dx))
                                      : SW'(0));
  assign sum_y = SW'(acc_y_r) - SW'($signed(cap_y)) +
                 (motion_sample.valid ? SW'($signed(motion_sample.dy))
                                      : SW'(0));
  assign ovf_x = sum_x > lim || sum_x < -lim;
  assign ovf_y = sum_y > lim || sum_y < -lim;
  assign full_x = SW'(acc_x_r) == lim || SW'(acc_x_r) == -lim;
  assign full_y = SW'(acc_y_r) == lim || SW'(acc_y_r) == -lim;

  assign motion_pending = acc_x_r != '0 || acc_y_r != '0;
  assign laser_cfg_complement_ok = laser_status.cfg0 == ~laser_status.cfg1;
  assign laser_fault = laser_status.bias_resistor_pin_short ||
                       laser_status.laser_drive_pin_short;

  always_comb begin
    status_byte = 8'h00;
    status_byte[motion_report_pkg::MOTION_PENDING_BIT]    = motion_pending;
    status_byte[motion_report_pkg::CFG_COMPLEMENT_OK_BIT] =
      laser_cfg_complement_ok;
    status_byte[motion_report_pkg::ACCUM_OVERFLOW_BIT]    = accum_overflow_r;
    status_byte[motion_report_pkg::LASER_FAULT_BIT]       = laser_fault;
  end

  always_ff @(posedge sys_clk) begin
    if (rst || clr_wr) begin
      acc_x_r <= '0;
      acc_y_r <= '0;
    end else begin
      acc_x_r <= clamp(sum_x, lim);
      acc_y_r <= clamp(sum_y, lim);
    end
  end

  // Set wins over the read-driven clear; lost counts stay lost
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      accum_overflow_r <= 1'b0;
    end else if (motion_sample.valid && (ovf_x || ovf_y)) begin
      accum_overflow_r <= 1'b1;
    end else if (clr_wr) begin
      accum_overflow_r <= 1'b0;
    end else if ((x_rd || y_rd) && !full_x && !full_y) begin
      accum_overflow_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || clr_wr) begin
      disp_x_r <= motion_report_pkg::DISP_RESET;
      disp_y_r <= motion_report_pkg::DISP_RESET;
    end else if (status_rd) begin
      disp_x_r <= cap_x;
      disp_y_r <= cap_y;
    end else begin
      if (x_rd) begin
        disp_x_r <= 8'h00;
      end
      if (y_rd) begin
        disp_y_r <= 8'h00;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        motion_report_pkg::MOTION_STATUS_ADDR: reg_rdata_r <= status_byte;
        motion_report_pkg::X_DISP_ADDR:        reg_rdata_r <= disp_x_r;
        motion_report_pkg::Y_DISP_ADDR:        reg_rdata_r <= disp_y_r;
        default:                               reg_rdata_r <= 8'h00;
      endcase
    end
  end

  assign reg_rdata = reg_rdata_r;

  a_status_pending: assert property (
    @(posedge sys_clk) disable iff (rst)
    status_rd |=> reg_rdata[7] == ($past(acc_x_r) != '0 ||
                                   $past(acc_y_r) != '0))
    else $error("pending bit does not follow accumulators");

  a_cfg_complement: assert property (
    @(posedge sys_clk) disable iff (rst)
    status_rd |=> reg_rdata[5] ==
      ($past(laser_status.cfg0) == ~$past(laser_status.cfg1)))
    else $error("complement bit wrong");

  a_overflow_bit: assert property (
    @(posedge sys_clk) disable iff (rst)
    status_rd |=> reg_rdata[4] == $past(accum_overflow_r))
    else $error("overflow bit not reported");

  a_laser_fault: assert property (
    @(posedge sys_clk) disable iff (rst)
    status_rd |=> reg_rdata[1] ==
      ($past(laser_status.bias_resistor_pin_short) ||
       $past(laser_status.laser_drive_pin_short)))
    else $error("fault bit wrong");

  a_reserved_zero: assert property (
    @(posedge sys_clk) disable iff (rst)
    status_rd |=> (reg_rdata & motion_report_pkg::STATUS_RESERVED_MASK)
                  == 8'h00)
    else $error("reserved status bit set");

  a_snapshot_hold: assert property (
    @(posedge sys_clk) disable iff (rst)
    !status_rd && !x_rd && !clr_wr |=> $stable(disp_x_r))
    else $error("x snapshot moved without a read");

  a_disp_clear: assert property (
    @(posedge sys_clk) disable iff (rst)
    x_rd && !status_rd && !clr_wr |=> disp_x_r == 8'h00)
    else $error("x displacement not cleared by read");

  a_full_scale: assert property (
    @(posedge sys_clk) disable iff (rst)
    status_rd && !clr_wr && acc_x_r > $signed(ACC_W'(127))
      |=> disp_x_r == motion_report_pkg::DISP_POS_FULL)
    else $error("x not at positive full scale");

  a_motion_clear: assert property (
    @(posedge sys_clk) disable iff (rst)
    clr_wr |=> acc_x_r == '0 && acc_y_r == '0 && disp_x_r == 8'h00)
    else $error("motion clear did not discard motion");

  a_overflow_set: assert property (
    @(posedge sys_clk) disable iff (rst)
    motion_sample.valid && (ovf_x || ovf_y) |=> accum_overflow_r)
    else $error("overflow not flagged");

endmodule // motion_report_registers

// file: pkg/motion_report_pkg.sv
// Constants, carriers and function summary for the motion report block
// Function
// - Status bit 7 shows unread accumulated motion is pending, else zero.
// - Status bit 5 is one when laser configs 0x2C/0x2D are complementary.
// - Status bit 4 is one if an accumulator overflowed since last report.
// - Status bit 1 is one when a laser pin short to ground is detected.
// - Reading status snapshots X and Y motion into the displacement regs.
// - Second status read before displacement reads discards earlier snapshot.
// - Accumulators are wider than eight bits; overflow sets the flag.
// - Overflow clears after a displacement read unless an axis is full scale.
// - While more motion remains, displacement reports full scale.
// - Accumulator depth scales with resolution: 32 reads at 800 cpi.
// - Any write to motion clear at 0x12 discards all accumulated motion.
// - Displacements are 8-bit two's complement, 80 hex to 7F hex.
// - Displacement counts motion since last report at current resolution.
// - Reading a displacement register clears it.
package motion_report_pkg;

  localparam logic [6:0] MOTION_STATUS_ADDR  = 7'h02;
  localparam logic [6:0] X_DISP_ADDR         = 7'h03;
  localparam logic [6:0] Y_DISP_ADDR         = 7'h04;
  localparam logic [6:0] MOTION_CLEAR_ADDR   = 7'h12;

  localparam int MOTION_PENDING_BIT          = 7;
  localparam int CFG_COMPLEMENT_OK_BIT       = 5;
  localparam int ACCUM_OVERFLOW_BIT          = 4;
  localparam int LASER_FAULT_BIT             = 1;

  localparam logic [7:0] MOTION_STATUS_RESET = 8'h20;
  localparam logic [7:0] DISP_RESET          = 8'h00;
  localparam logic [7:0] LASER_CFG0_RESET    = 8'h7F;
  localparam logic [7:0] LASER_CFG1_RESET    = 8'h80;
  localparam logic [7:0] STATUS_RESERVED_MASK = 8'h4D;
  localparam logic [7:0] DISP_POS_FULL       = 8'h7F;
  localparam logic [7:0] DISP_NEG_FULL       = 8'h80;

  // Resolution is given in units of 200 cpi; 800 cpi is 4 units
  localparam int RES_UNIT_W                  = 4;
  // Full scale per resolution unit: 4 units x 1024 = 32 reads of 128
  localparam int FULL_SCALE_SHIFT            = 10;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [6:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] dx;
    logic [7:0] dy;
  } motion_sample_type;

  typedef struct packed {
    logic [7:0] cfg0;
    logic [7:0] cfg1;
    logic       bias_resistor_pin_short;
    logic       laser_drive_pin_short;
  } laser_status_type;

endpackage

// file: verification/motion_host_model.sv
// Host side model that polls the motion report registers
`timescale 1ns/1ps
module motion_host_model (
  input  wire logic                      sys_clk,
  output motion_report_pkg::reg_req_type reg_req
);
  initial reg_req = '0;

  // One strobe per access; rd is the inverse of wr
  task automatic access(logic wr, logic [6:0] a, logic [7:0] d);
    @(posedge sys_clk);
    #1 reg_req = '{rd: ~wr, wr: wr, addr: a, wdata: d};
    @(posedge sys_clk);
    // Idle bus carries inverted values, never the old request
    #1 reg_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask

  task automatic poll();
    access(1'b0, motion_report_pkg::MOTION_STATUS_ADDR, 8'h00);
    access(1'b0, motion_report_pkg::X_DISP_ADDR, 8'h00);
    access(1'b0, motion_report_pkg::Y_DISP_ADDR, 8'h00);
  endtask
endmodule // motion_host_model

// file: verification/tb_top.sv
// Self-checking bench for the motion report registers
`timescale 1ns/1ps
module tb_top;
  logic                                    sys_clk = 1'b0;
  logic                                    rst = 1'b1;
  motion_report_pkg::reg_req_type          reg_req;
  logic [7:0]                              reg_rdata;
  motion_report_pkg::motion_sample_type    motion_sample = '0;
  logic [motion_report_pkg::RES_UNIT_W-1:0] res_units = 4'h4;
  motion_report_pkg::laser_status_type     laser_status;
  logic [7:0]                              q[$];
  logic                                    rd_d = 1'b0;
  int n_fail = 0, num_checks = 0, cyc = 0;
  int ax = 0, ay = 0, sx = 0, sy = 0, ovf = 0, fs = 4096, i, k, n;

  always #25 sys_clk = ~sys_clk;

  motion_report_registers #(.ACC_W(16)) u_motion_report_registers (
    .sys_clk(sys_clk), .rst(rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .motion_sample(motion_sample),
    .res_units(res_units), .laser_status(laser_status));

  motion_host_model u_motion_host_model (
    .sys_clk(sys_clk), .reg_req(reg_req));

  function automatic int sat(int a);
    return a > 127 ? 127 : (a < -128 ? -128 : a);
  endfunction

  function automatic int lim(int a);
    if (a > fs || a < -fs) ovf = 1;
    return a > fs ? fs : (a < -fs ? -fs : a);
  endfunction

  task automatic give_verdict();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(logic [7:0] seen, logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: read %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic note_status();
    logic [7:0] st;
    st = {(ax != 0 || ay != 0), 1'b0,
          laser_status.cfg0 === ~laser_status.cfg1, ovf[0], 2'b00,
          laser_status.bias_resistor_pin_short |
          laser_status.laser_drive_pin_short, 1'b0};
    q.push_back(st);
    sx = sat(ax);
    sy = sat(ay);
    ax -= sx;
    ay -= sy;
  endtask

  task automatic note_disp(bit y);
    q.push_back(8'(y ? sy : sx));
    if (y)
      sy = 0;
    else
      sx = 0;
    // overflow drops once off full scale
    if (ax != fs && ax != -fs && ay != fs && ay != -fs) ovf = 0;
  endtask

  task automatic rd(logic [6:0] a);
    case (a)
      7'h02: note_status();
      7'h03: note_disp(1'b0);
      7'h04: note_disp(1'b1);
      default: q.push_back(8'h00);
    endcase
    u_motion_host_model.access(1'b0, a, 8'h00);
  endtask

  task automatic read_cycle();
    note_status();
    note_disp(1'b0);
    note_disp(1'b1);
    u_motion_host_model.poll();
  endtask

  task automatic add(int dx, int dy);
    @(posedge sys_clk);
    #1 motion_sample = '{1'b1, dx[7:0], dy[7:0]};
    ax = lim(ax + dx);
    ay = lim(ay + dy);
    @(posedge sys_clk);
    #1 motion_sample = '{1'b0, ~dx[7:0], ~dy[7:0]};
  endtask

  task automatic drain(output int cnt);
    cnt = 0;
    while (ax != 0 || ay != 0) begin
      read_cycle();
      cnt++;
    end
    read_cycle();
  endtask

  always @(posedge sys_clk) begin
    rd_d <= reg_req.rd & ~rst;
    cyc <= cyc + 1;
    if (rd_d && q.size() == 0) n_fail++;
    if (rd_d && q.size() != 0) check(reg_rdata, q.pop_front());
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    void'($urandom(62024));
    laser_status = '{8'h7F, 8'h80, 1'b0, 1'b0};
    repeat (16) @(posedge sys_clk);
    #1 rst = 1'b0;
    read_cycle();
    repeat (20) begin
      k = $urandom_range(3, 1);
      repeat (k) add($urandom_range(80) - 40, $urandom_range(80) - 40);
      read_cycle();
      read_cycle();
    end
    add(10, -3);
    rd(7'h02);
    add(20, 7);
    rd(7'h03);
    rd(7'h04);
    read_cycle();
    add(9, 9);
    rd(7'h02);
    rd(7'h02);
    read_cycle();
    for (i = 0; i < 8; i++) begin
      k = $urandom_range(255);
      laser_status = '{k[7:0], i[2] ? ~k[7:0] : k[7:0] ^ 8'h01, i[0], i[1]};
      rd(7'h02);
    end
    laser_status = '{8'h7F, 8'h80, 1'b0, 1'b0};
    rd(7'h05);
    res_units = 4'h1;
    fs = 1024;
    repeat (10) add(127, -128);
    drain(n);
    repeat (10) add(127, -128);
    u_motion_host_model.access(1'b1, 7'h03, 8'h5A);
    rd(7'h02);
    u_motion_host_model.access(1'b1, 7'h12, 8'hA5);
    ax = 0;
    ay = 0;
    sx = 0;
    sy = 0;
    ovf = 0;
    read_cycle();
    for (i = 4; i <= 8; i += 4) begin
      res_units = i[3:0];
      fs = i * 1024;
      repeat (i * 10) add(0, -128);
      drain(n);
      check(n[7:0], 8'(i * 8));
    end
    repeat (4) @(posedge sys_clk);
    give_verdict();
  end
endmodule // tb_top
